// *** design/eccr_pkg.sv ***
package eccr_pkg;
    // register offsets; the a copy sits at 0x08 by analogy with the other pairs
    localparam logic [7:0] ECCR_OFF_A = 8'h08;
    localparam logic [7:0] ECCR_OFF_B = 8'h28;
    localparam logic [7:0] ECCR_RESET = 8'hfb;
    // field positions
    localparam int ECCR_BIT_NLP_SEL = 0;
    localparam int ECCR_BIT_PATH_DET = 1;
    localparam int ECCR_BIT_PATH_CLR = 2;
    localparam int ECCR_BIT_RESERVED = 3;
    localparam int ECCR_BIT_RING = 4;
    localparam int ECCR_BIT_REJ_ECHO = 5;
    localparam int ECCR_BIT_INJ = 6;
    localparam int ECCR_BIT_REJ_DT = 7;

    // decoded controls of one canceller
    typedef struct packed {
        logic noise_est_reject_doubletalk;
        logic noise_est_reject_echo;
        logic instability_detect_enable;
        logic path_change_detect_enable;
        logic nonlinear_proc_variant_select;
        logic reserved_ok;
    } eccr_ctrl_s;

    // path change actions
    typedef struct packed {
        logic clear_estimate;
        logic fast_converge;
    } eccr_path_s;
endpackage : eccr_pkg

// *** design/eccr_top.sv ***
module eccr_top (
    input wire logic pclk, // apb clock, 50 mhz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic [1:0] path_change_in, // path change event per canceller, same clock
    output eccr_pkg::eccr_ctrl_s [1:0] ctrl_out, // decoded controls per canceller
    output eccr_pkg::eccr_path_s [1:0] path_out // path change actions, one cycle behind the event and high for as long as it is held
);
    import eccr_pkg::*;

    logic [1:0][7:0] reg_q, reg_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    eccr_ctrl_s [1:0] ctrl_q, ctrl_d;
    eccr_path_s [1:0] path_q, path_d;
    logic hit_a, hit_b;

    // decoded power-up controls, so ctrl_out agrees with the register from the first edge after reset
    localparam eccr_ctrl_s ECCR_CTRL_RST = '{
        noise_est_reject_doubletalk: ECCR_RESET[ECCR_BIT_REJ_DT],
        noise_est_reject_echo: ECCR_RESET[ECCR_BIT_REJ_ECHO],
        instability_detect_enable: ECCR_RESET[ECCR_BIT_RING],
        path_change_detect_enable: ECCR_RESET[ECCR_BIT_PATH_DET],
        nonlinear_proc_variant_select: ECCR_RESET[ECCR_BIT_NLP_SEL],
        reserved_ok: ECCR_RESET[ECCR_BIT_RESERVED]
    };

    assign hit_a = (paddr == ECCR_OFF_A);
    assign hit_b = (paddr == ECCR_OFF_B);

    // bus slave: one wait state, answer on the second cycle of the access phase
    // writes commit one edge before the taking edge, at the edge that raises pready; an apb access cannot be withdrawn
    always_comb begin
        reg_d = reg_q;
        prdata_d = 32'h0;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q) begin
            pready_d = 1'b1;
            pslverr_d = !(hit_a || hit_b);
            if (pwrite && hit_a) begin
                reg_d[0] = pwdata[7:0];
            end
            if (pwrite && hit_b) begin
                reg_d[1] = pwdata[7:0];
            end
            if (!pwrite && hit_a) begin
                prdata_d = {24'h0, reg_q[0]};
            end
            if (!pwrite && hit_b) begin
                prdata_d = {24'h0, reg_q[1]};
            end
        end
    end

    // decode per canceller; outputs registered so they come from flops
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ctrl_d[i].noise_est_reject_doubletalk = reg_d[i][ECCR_BIT_REJ_DT];
            ctrl_d[i].noise_est_reject_echo = reg_d[i][ECCR_BIT_REJ_ECHO];
            ctrl_d[i].instability_detect_enable = reg_d[i][ECCR_BIT_RING];
            ctrl_d[i].path_change_detect_enable = reg_d[i][ECCR_BIT_PATH_DET];
            ctrl_d[i].nonlinear_proc_variant_select = reg_d[i][ECCR_BIT_NLP_SEL];
            // reserved bit left low means software broke the write-as-one contract
            ctrl_d[i].reserved_ok = reg_d[i][ECCR_BIT_RESERVED];
            // detector gated by its enable, so the clear bit is ignored when off
            path_d[i].fast_converge = path_change_in[i] && reg_q[i][ECCR_BIT_PATH_DET];
            path_d[i].clear_estimate = path_change_in[i] && reg_q[i][ECCR_BIT_PATH_DET]
                && reg_q[i][ECCR_BIT_PATH_CLR];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_q <= {ECCR_RESET, ECCR_RESET};
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q <= {ECCR_CTRL_RST, ECCR_CTRL_RST};
            path_q <= '0;
        end else begin
            reg_q <= reg_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_q <= ctrl_d;
            path_q <= path_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign ctrl_out = ctrl_q;
    assign path_out = path_q;

    // checks
    fast_on_change_a: assert property (@(posedge pclk) disable iff (!presetn)
        path_change_in[1] && reg_q[1][ECCR_BIT_PATH_DET] |=> path_out[1].fast_converge)
        else $error("no fast convergence on path change");
    clear_on_change_a: assert property (@(posedge pclk) disable iff (!presetn)
        path_change_in[0] && reg_q[0][ECCR_BIT_PATH_DET] && reg_q[0][ECCR_BIT_PATH_CLR]
        |=> path_out[0].clear_estimate)
        else $error("estimate not cleared");
    keep_estimate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !reg_q[0][ECCR_BIT_PATH_CLR] |=> !path_out[0].clear_estimate)
        else $error("estimate cleared with clear bit low");
    detect_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
        !reg_q[1][ECCR_BIT_PATH_DET] |=> path_out[1] == '0)
        else $error("path action with detector off");
    b_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && pwrite && paddr == 8'h28 |=> reg_q[1] == $past(pwdata[7:0]))
        else $error("b register not written");
    b_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !pwrite && paddr == 8'h28 |=> pready && prdata[7:0] == $past(reg_q[1]))
        else $error("b register read wrong");
    reject_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ctrl_out[0].noise_est_reject_doubletalk == $past(reg_q[0][ECCR_BIT_REJ_DT], 1)
        || $past(psel && penable && pwrite))
        else $error("doubletalk rejection mismatch");
    nlp_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[1].nonlinear_proc_variant_select == reg_q[1][ECCR_BIT_NLP_SEL])
        else $error("nlp select mismatch");
    ring_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[0].instability_detect_enable == reg_q[0][ECCR_BIT_RING])
        else $error("instability enable mismatch");
    reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[1].reserved_ok == reg_q[1][ECCR_BIT_RESERVED])
        else $error("reserved flag mismatch");
    // bus timing: one wait state, ready stands one cycle, read data zero outside the answer
    ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("no ready after access");
    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held past one cycle");
    idle_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable) |=> !pready)
        else $error("ready without access");
    rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // address map: only the two copies answer without error, and only a write moves a register
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && paddr != ECCR_OFF_A && paddr != ECCR_OFF_B
        |=> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && (paddr == ECCR_OFF_A || paddr == ECCR_OFF_B) |=> !pslverr)
        else $error("error on mapped access");
    b_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable && !pready && pwrite && paddr == ECCR_OFF_B) |=> $stable(reg_q[1]))
        else $error("b register changed without write");
    a_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && pwrite && paddr == ECCR_OFF_A |=> reg_q[0] == $past(pwdata[7:0]))
        else $error("a register not written");
    a_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !pwrite && paddr == ECCR_OFF_A |=> pready && prdata[7:0] == $past(reg_q[0]))
        else $error("a register read wrong");
    a_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable && !pready && pwrite && paddr == ECCR_OFF_A) |=> $stable(reg_q[0]))
        else $error("a register changed without write");
    // path actions on the canceller that the checks above leave out, then clear-with-fast and no-action-without-event checks on both
    a_fast_change_a: assert property (@(posedge pclk) disable iff (!presetn)
        path_change_in[0] && reg_q[0][ECCR_BIT_PATH_DET] |=> path_out[0].fast_converge)
        else $error("a no fast convergence on path change");
    b_clear_change_a: assert property (@(posedge pclk) disable iff (!presetn)
        path_change_in[1] && reg_q[1][ECCR_BIT_PATH_DET] && reg_q[1][ECCR_BIT_PATH_CLR] |=> path_out[1].clear_estimate)
        else $error("b estimate not cleared");
    b_keep_estimate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !reg_q[1][ECCR_BIT_PATH_CLR] |=> !path_out[1].clear_estimate)
        else $error("b estimate cleared with clear bit low");
    a_detect_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
        !reg_q[0][ECCR_BIT_PATH_DET] |=> path_out[0] == '0)
        else $error("a path action with detector off");
    a_clear_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
        path_out[0].clear_estimate |-> path_out[0].fast_converge)
        else $error("a clear without fast convergence");
    b_clear_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
        path_out[1].clear_estimate |-> path_out[1].fast_converge)
        else $error("b clear without fast convergence");
    a_quiet_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !path_change_in[0] |=> path_out[0] == '0)
        else $error("a path action without event");
    b_quiet_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !path_change_in[1] |=> path_out[1] == '0)
        else $error("b path action without event");
    // decoded controls of the fields the checks above leave out
    b_dt_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[1].noise_est_reject_doubletalk == reg_q[1][ECCR_BIT_REJ_DT])
        else $error("b doubletalk rejection mismatch");
    a_echo_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[0].noise_est_reject_echo == reg_q[0][ECCR_BIT_REJ_ECHO])
        else $error("a echo rejection mismatch");
    b_echo_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[1].noise_est_reject_echo == reg_q[1][ECCR_BIT_REJ_ECHO])
        else $error("b echo rejection mismatch");
    a_det_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[0].path_change_detect_enable == reg_q[0][ECCR_BIT_PATH_DET])
        else $error("a detect enable mismatch");
    b_det_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[1].path_change_detect_enable == reg_q[1][ECCR_BIT_PATH_DET])
        else $error("b detect enable mismatch");
    a_nlp_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[0].nonlinear_proc_variant_select == reg_q[0][ECCR_BIT_NLP_SEL])
        else $error("a nlp select mismatch");
    b_ring_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[1].instability_detect_enable == reg_q[1][ECCR_BIT_RING])
        else $error("b instability enable mismatch");
    a_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_out[0].reserved_ok == reg_q[0][ECCR_BIT_RESERVED])
        else $error("a reserved flag mismatch");
    cv_write_b: cover property (@(posedge pclk) psel && penable && pready && pwrite && paddr == 8'h28);
    cv_clear: cover property (@(posedge pclk) path_out[0].clear_estimate);
    cv_keep: cover property (@(posedge pclk) path_out[1].fast_converge && !path_out[1].clear_estimate);
    cv_err: cover property (@(posedge pclk) pready && pslverr);
    cv_det_off: cover property (@(posedge pclk) path_change_in[1] && !reg_q[1][ECCR_BIT_PATH_DET]);
endmodule : eccr_top

// *** verif/tb_eccr_top.sv ***
module tb_eccr_top;
    timeunit 1ns;
    timeprecision 1ns;
    import eccr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 0, a;
    logic [31:0] pwdata = 0, prdata, d;
    logic [1:0] path_change_in = 0;
    eccr_ctrl_s [1:0] ctrl_out;
    eccr_path_s [1:0] path_out;
    logic [32:0] exp_q[$];
    logic [7:0] regs [2];
    int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 51;
    eccr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .path_change_in(path_change_in), .ctrl_out(ctrl_out), .path_out(path_out));
    // 50 mhz clock
    initial begin
        forever #10 pclk = ~pclk;
    end
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task summarize;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // expected decode of a register byte into the control struct
    function automatic logic [5:0] dec(input logic [7:0] v);
        return {v[7], v[5], v[4], v[1], v[0], v[3]};
    endfunction : dec
    // one apb transfer; every transfer queues its expected answer at setup so the monitor never waits on it
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        if (w) exp_q.push_back({(ad != ECCR_OFF_A && ad != ECCR_OFF_B), 32'h0});
        else if (ad == ECCR_OFF_A) exp_q.push_back({25'h0, regs[0]});
        else if (ad == ECCR_OFF_B) exp_q.push_back({25'h0, regs[1]});
        else exp_q.push_back({1'b1, 32'h0});
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (!pready);
        psel <= 0;
        penable <= 0;
        if (w && ad == ECCR_OFF_A) regs[0] = wd[7:0];
        if (w && ad == ECCR_OFF_B) regs[1] = wd[7:0];
    endtask : apb
    // timeout guard and response scoreboard for every transfer; a hang counts as a mismatch
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready) chk({pslverr, prdata}, exp_q.pop_front());
        if (cyc == 4000) begin
            n_mismatch++;
            summarize();
        end
    end
    // reset, power-up values, unmapped access, then random writes with every path-control combination
    initial begin
        regs[0] = ECCR_RESET;
        regs[1] = ECCR_RESET;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 chk(33'(ctrl_out), 33'({dec(ECCR_RESET), dec(ECCR_RESET)}));
        apb(1'b1, 8'h29, 32'h0000_00ff);
        apb(1'b0, ECCR_OFF_A, 32'h0);
        apb(1'b0, ECCR_OFF_B, 32'h0);
        apb(1'b0, 8'h29, 32'h0);
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            d[3] = 1'b1;
            d[2:1] = i[2:1];
            a = i[0] ? ECCR_OFF_B : ECCR_OFF_A;
            apb(1'b1, a, d);
            apb(1'b0, a, 32'h0);
            chk(33'(ctrl_out[i[0]]), 33'(dec(d[7:0])));
            @(posedge pclk);
            path_change_in[i[0]] <= 1'b1;
            @(posedge pclk);
            path_change_in <= 2'b00;
            #1 chk(33'(path_out), 33'({2'b00, d[1] & d[2], d[1]} << (2 * i[0])));
        end
        // mid-run reset must bring both copies back to their power-up value
        @(posedge pclk);
        presetn <= 1'b0;
        regs[0] = ECCR_RESET;
        regs[1] = ECCR_RESET;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 chk(33'(ctrl_out), 33'({dec(ECCR_RESET), dec(ECCR_RESET)}));
        apb(1'b0, ECCR_OFF_B, 32'h0);
        apb(1'b0, ECCR_OFF_A, 32'h0);
        summarize();
    end
endmodule : tb_eccr_top
